// File: port_vc_arb_pkg.sv
// Register map, field layout and timing constants of the port VC arbitration register group.
package port_vc_arb_pkg;

  // ==========================================================================
  // Register byte addresses
  localparam logic [11:0] ADDR_VC_CAP_TWO = 12'h148;
  localparam logic [11:0] ADDR_VC_CTRL_STAT = 12'h14c;
  localparam logic [11:0] ADDR_VC_RES_CAP_ZERO = 12'h150;
  localparam logic [11:0] ADDR_VC_ARB_TABLE = 12'h160;
  localparam logic [11:0] ADDR_EXT_VC_COUNT = 12'h170;
  localparam logic [11:0] ADDR_ARB_ACTIVE = 12'h174;

  // ==========================================================================
  // Field positions
  localparam int LOAD_BIT = 0;
  localparam int SEL_LSB = 1;
  localparam int SEL_W = 3;
  localparam int STATUS_BIT = 16;
  localparam int TBL_OFS_LSB = 24;
  localparam int APS_BIT = 14;
  localparam int RSNP_BIT = 15;
  localparam int MTS_LSB = 16;

  // ==========================================================================
  // Read-only values, reset values and select codes
  localparam logic [7:0] VC_ARB_CAP_NONE = 8'h00;
  localparam logic [7:0] VC_ARB_CAP_ONE = 8'h03;
  localparam logic [7:0] VC_TBL_OFS_NONE = 8'h00;
  localparam logic [7:0] VC_TBL_OFS_ONE = 8'h03;
  localparam logic [7:0] PORT_ARB_CAP_ZERO = 8'h09;
  localparam logic [6:0] MAX_TIME_SLOTS = 7'h7f;
  localparam logic [7:0] PORT_TBL_OFS_ZERO = 8'h04;
  localparam logic [2:0] EXT_VC_COUNT_RESET = 3'h0;
  localparam logic [2:0] SEL_RESET = 3'h0;
  localparam logic [2:0] SEL_ROUND_ROBIN = 3'h0;
  localparam logic [2:0] SEL_WRR32 = 3'h1;

  // ==========================================================================
  // Table geometry and load timing
  localparam int WRR_PHASES = 32;
  localparam int PHASE_BITS = 4;
  localparam int TABLE_WORDS = WRR_PHASES * PHASE_BITS / 32;
  localparam int LOAD_CYCLES_PER_WORD = 1;

  typedef enum logic [1:0] {
    ARB_ROUND_ROBIN,
    ARB_WRR32
  } arb_scheme_t;

endpackage : port_vc_arb_pkg

// File: port_vc_arbitration_regs.sv
// Port VC arbitration capability, control and status registers on an APB slave.
//
// Operation
// - A one written to control bit 0 copies the stored VC arbitration table into the active table.
// - The load control bit reads back as zero at all times and from reset.
// - The select field in bits 3:1 resets to zero and any value other than 0 or 1 acts as 0.
// - A software write to any arbitration table entry sets the status flag in bit 16.
// - The status flag clears once the hardware load started by the load bit has finished.
// - Capability bits 7:0 read 00h with no extended VC and 03h with one extended VC.
// - The low-priority group supports fixed round robin and 32-phase weighted round robin.
// - Table offset bits 31:24 read 00h with no extended VC and 03h with one, in 16-byte units.
// - Port arbitration capability of VC resource 0 reads 09h.
// - Bits 14 and 15 of VC resource 0 capability read as zero.
// - Maximum time slots in bits 22:16 read 7Fh.
// - Port arbitration table offset in bits 31:24 of VC resource 0 capability reads 04h.
// - The extended VC count in bits 2:0 selects between the alternative reset values.
`timescale 1ns/10ps
module port_vc_arbitration_regs #(
  parameter int ADDR_W = 12
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Arbiter side
  output logic [1:0] vc_arb_scheme,
  output logic [31:0] active_table [port_vc_arb_pkg::TABLE_WORDS],
  output logic table_loading
);

  // ==========================================================================
  // Elaboration check
  if (ADDR_W < 12) begin : g_bad_addr
    $error("ADDR_W must be at least 12");
  end

  localparam int TW = port_vc_arb_pkg::TABLE_WORDS;
  localparam int IW = $clog2(TW);

  typedef enum logic [0:0] {
    LD_IDLE,
    LD_COPY
  } load_state_t;

  // ==========================================================================
  // State
  logic [2:0] arb_select;
  logic table_status;
  logic [2:0] ext_vc_count;
  logic [31:0] stored_table [TW];
  load_state_t load_state;
  logic [IW-1:0] load_idx;
  logic [2:0] next_arb_select;
  logic next_table_status;
  logic [2:0] next_ext_vc_count;
  logic [31:0] next_stored_table [TW];
  logic [31:0] next_active_table [TW];
  load_state_t next_load_state;
  logic [IW-1:0] next_load_idx;
  logic [31:0] next_prdata;

  logic access;
  logic wr;
  logic [11:0] addr;
  logic tbl_hit;
  logic [IW-1:0] tbl_idx;
  logic load_req;
  logic load_done;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = wd[8*b +: 8];
      end
    end
    return res;
  endfunction : merge

  // Reset-value selection by extended VC count; count 1 picks the one-VC value, every other count the no-VC value.
  function automatic logic [7:0] by_ext(input logic [2:0] cnt, input logic [7:0] v0,
                                        input logic [7:0] v1);
    return (cnt == 3'h1) ? v1 : v0;
  endfunction : by_ext

  assign access = psel && penable;
  assign wr = access && pwrite;
  assign addr = paddr[11:0];
  assign tbl_hit = (addr >= port_vc_arb_pkg::ADDR_VC_ARB_TABLE)
    && (addr < port_vc_arb_pkg::ADDR_VC_ARB_TABLE + 12'(4 * TW));
  assign tbl_idx = IW'((addr - port_vc_arb_pkg::ADDR_VC_ARB_TABLE) >> 2);
  assign load_req = wr && (addr == port_vc_arb_pkg::ADDR_VC_CTRL_STAT) && pstrb[0]
    && pwdata[port_vc_arb_pkg::LOAD_BIT];
  assign load_done = (load_state == LD_COPY) && (load_idx == IW'(TW - 1));

  // Every access completes without wait states; unmapped addresses answer zero with no error.
  assign pready = 1'b1;
  assign pslverr = 1'b0;

  // ==========================================================================
  // Next values
  always_comb begin
    next_arb_select = arb_select;
    next_table_status = table_status;
    next_ext_vc_count = ext_vc_count;
    next_stored_table = stored_table;
    next_active_table = active_table;
    next_load_state = load_state;
    next_load_idx = load_idx;
    if (wr && addr == port_vc_arb_pkg::ADDR_VC_CTRL_STAT && pstrb[0]) begin
      next_arb_select = pwdata[port_vc_arb_pkg::SEL_LSB +: port_vc_arb_pkg::SEL_W];
    end
    if (wr && addr == port_vc_arb_pkg::ADDR_EXT_VC_COUNT && pstrb[0]) begin
      next_ext_vc_count = pwdata[2:0];
    end
    unique case (load_state)
      LD_IDLE: begin
        if (load_req) begin
          next_load_state = LD_COPY;
          next_load_idx = '0;
        end
      end
      LD_COPY: begin
        next_active_table[load_idx] = stored_table[load_idx];
        next_load_idx = load_idx + 1'b1;
        if (load_done) begin
          next_load_state = LD_IDLE;
          next_table_status = 1'b0;
        end
      end
    endcase
    // A table write in the finishing cycle keeps the flag set, so set wins over clear.
    if (wr && tbl_hit) begin
      next_stored_table[tbl_idx] = merge(stored_table[tbl_idx], pwdata, pstrb);
      next_table_status = 1'b1;
    end
  end

  // ==========================================================================
  // Read data
  always_comb begin
    next_prdata = 32'h0000_0000;
    if (psel && !penable && !pwrite) begin
      unique case (addr)
        port_vc_arb_pkg::ADDR_VC_CAP_TWO: begin
          next_prdata[7:0] = by_ext(ext_vc_count, port_vc_arb_pkg::VC_ARB_CAP_NONE,
                                    port_vc_arb_pkg::VC_ARB_CAP_ONE);
          next_prdata[port_vc_arb_pkg::TBL_OFS_LSB +: 8] = by_ext(ext_vc_count,
            port_vc_arb_pkg::VC_TBL_OFS_NONE, port_vc_arb_pkg::VC_TBL_OFS_ONE);
        end
        port_vc_arb_pkg::ADDR_VC_CTRL_STAT: begin
          next_prdata[port_vc_arb_pkg::LOAD_BIT] = 1'b0;
          next_prdata[port_vc_arb_pkg::SEL_LSB +: port_vc_arb_pkg::SEL_W] = arb_select;
          next_prdata[port_vc_arb_pkg::STATUS_BIT] = table_status;
        end
        port_vc_arb_pkg::ADDR_VC_RES_CAP_ZERO: begin
          next_prdata[7:0] = port_vc_arb_pkg::PORT_ARB_CAP_ZERO;
          next_prdata[port_vc_arb_pkg::APS_BIT] = 1'b0;
          next_prdata[port_vc_arb_pkg::RSNP_BIT] = 1'b0;
          next_prdata[port_vc_arb_pkg::MTS_LSB +: 7] = port_vc_arb_pkg::MAX_TIME_SLOTS;
          next_prdata[port_vc_arb_pkg::TBL_OFS_LSB +: 8] =
            port_vc_arb_pkg::PORT_TBL_OFS_ZERO;
        end
        port_vc_arb_pkg::ADDR_EXT_VC_COUNT: begin
          next_prdata[2:0] = ext_vc_count;
        end
        port_vc_arb_pkg::ADDR_ARB_ACTIVE: begin
          next_prdata[1:0] = vc_arb_scheme;
          next_prdata[2] = table_loading;
        end
        default: begin
          if (tbl_hit) begin
            next_prdata = stored_table[tbl_idx];
          end
        end
      endcase
    end
  end

  // ==========================================================================
  // Registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      arb_select <= port_vc_arb_pkg::SEL_RESET;
      table_status <= 1'b0;
      ext_vc_count <= port_vc_arb_pkg::EXT_VC_COUNT_RESET;
      stored_table <= '{default: 32'h0000_0000};
      active_table <= '{default: 32'h0000_0000};
      load_state <= LD_IDLE;
      load_idx <= '0;
      prdata <= 32'h0000_0000;
    end else begin
      arb_select <= next_arb_select;
      table_status <= next_table_status;
      ext_vc_count <= next_ext_vc_count;
      stored_table <= next_stored_table;
      active_table <= next_active_table;
      load_state <= next_load_state;
      load_idx <= next_load_idx;
      prdata <= next_prdata;
    end
  end

  // Read data is captured at the setup edge, so it stands through the whole access phase.
  // A status change at that same edge shows only on the next read of the word.
  // Selection is decoded combinationally so the arbiters see a legal scheme at once.
  always_comb begin
    if (arb_select == port_vc_arb_pkg::SEL_WRR32) begin
      vc_arb_scheme = port_vc_arb_pkg::ARB_WRR32;
    end else begin
      vc_arb_scheme = port_vc_arb_pkg::ARB_ROUND_ROBIN;
    end
  end
  assign table_loading = (load_state == LD_COPY);

  // ==========================================================================
  // Checks
  property p_load_starts;
    @(posedge pclk) disable iff (!presetn)
      (load_req && load_state == LD_IDLE) |=> table_loading;
  endproperty
  a_load_starts: assert property (p_load_starts) else $error("load did not start");

  property p_load_reads_zero;
    @(posedge pclk) disable iff (!presetn)
      (access && !pwrite && addr == port_vc_arb_pkg::ADDR_VC_CTRL_STAT) |-> !prdata[0];
  endproperty
  a_load_reads_zero: assert property (p_load_reads_zero) else $error("load bit read one");

  property p_sel_default;
    @(posedge pclk) disable iff (!presetn)
      (arb_select > port_vc_arb_pkg::SEL_WRR32) |->
      vc_arb_scheme == port_vc_arb_pkg::ARB_ROUND_ROBIN;
  endproperty
  a_sel_default: assert property (p_sel_default) else $error("illegal select not default");

  property p_status_set;
    @(posedge pclk) disable iff (!presetn)
      (wr && tbl_hit) |=> table_status;
  endproperty
  a_status_set: assert property (p_status_set) else $error("status not set by write");

  property p_status_clear;
    @(posedge pclk) disable iff (!presetn)
      (load_done && !(wr && tbl_hit)) |=> !table_status && !table_loading;
  endproperty
  a_status_clear: assert property (p_status_clear) else $error("status not cleared");

  property p_load_bounded;
    @(posedge pclk) disable iff (!presetn)
      $rose(table_loading) |-> ##[1:8] !table_loading;
  endproperty
  a_load_bounded: assert property (p_load_bounded) else $error("load never finished");

  property p_cap_two;
    @(posedge pclk) disable iff (!presetn)
      (access && !pwrite && addr == port_vc_arb_pkg::ADDR_VC_CAP_TWO && ext_vc_count == 3'h1)
      |-> prdata == 32'h0300_0003;
  endproperty
  a_cap_two: assert property (p_cap_two) else $error("capability two wrong");

  property p_res_cap;
    @(posedge pclk) disable iff (!presetn)
      (access && !pwrite && addr == port_vc_arb_pkg::ADDR_VC_RES_CAP_ZERO)
      |-> prdata == 32'h047f_0009;
  endproperty
  a_res_cap: assert property (p_res_cap) else $error("resource capability wrong");

  property p_unmapped_zero;
    @(posedge pclk) disable iff (!presetn)
      (access && !pwrite && addr == 12'h000) |-> prdata == 32'h0000_0000;
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read nonzero");

endmodule : port_vc_arbitration_regs

// File: tb_port_vc_arbitration_regs.sv
// Self-checking testbench for the port VC arbitration register group.
`timescale 1ns/10ps
module tb_port_vc_arbitration_regs;
  // ==========================================================================
  // Signals
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [3:0] pstrb;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [1:0] vc_arb_scheme;
  logic [31:0] act [port_vc_arb_pkg::TABLE_WORDS];
  logic table_loading;
  logic [31:0] tbl [port_vc_arb_pkg::TABLE_WORDS];
  logic [31:0] rd;
  logic [31:0] rnd;
  logic [3:0] stb;
  logic [2:0] cur_sel;
  int num_errors;
  int comparisons;
  int n;

  port_vc_arbitration_regs #(.ADDR_W(12)) u_dut (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .pstrb(pstrb),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .vc_arb_scheme(vc_arb_scheme),
    .active_table(act),
    .table_loading(table_loading)
  );

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // ==========================================================================
  // Tasks and expectation functions
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // Read data is taken at the access edge; the task returns at the falling edge after it,
  // so outputs launched by that edge have settled before the caller looks at them.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    check({31'h0, pslverr}, 32'h0);
    psel <= 1'b0;
    penable <= 1'b0;
    @(negedge pclk);
  endtask : apb

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) r[8*b +: 8] = d[8*b +: 8];
    end
    return r;
  endfunction : merge

  function automatic logic [31:0] ctrl_exp(input logic [2:0] sel, input logic st);
    return {15'h0, st, 12'h0, sel, 1'b0};
  endfunction : ctrl_exp

  task automatic load_check(input logic [2:0] sel);
    apb(1'b1, port_vc_arb_pkg::ADDR_VC_CTRL_STAT, {28'h0, sel, 1'b1}, 4'hf);
    check({31'h0, table_loading}, 32'h1);
    for (n = 0; n < 20 && table_loading !== 1'b0; n++) begin
      @(negedge pclk);
    end
    check({31'h0, table_loading}, 32'h0);
    for (int w = 0; w < port_vc_arb_pkg::TABLE_WORDS; w++) begin
      check(act[w], tbl[w]);
    end
    apb(1'b0, port_vc_arb_pkg::ADDR_VC_CTRL_STAT, 32'h0, 4'h0);
    check(rd, ctrl_exp(sel, 1'b0));
    cur_sel = sel;
  endtask : load_check

  task automatic finish_test;
    $display("comparisons %0d errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : finish_test

  // ==========================================================================
  // Main sequence
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'h0;
    num_errors = 0;
    comparisons = 0;
    cur_sel = 3'h0;
    foreach (tbl[i]) tbl[i] = 32'h0;
    n = $urandom(45199);
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, port_vc_arb_pkg::ADDR_VC_CTRL_STAT, 32'h0, 4'h0);
    check(rd, 32'h0);
    check({30'h0, vc_arb_scheme}, 32'h0);
    // Read-only words must shrug off random writes.
    for (int k = 0; k < 3; k++) begin
      apb(1'b1, port_vc_arb_pkg::ADDR_VC_RES_CAP_ZERO, $urandom, 4'hf);
      apb(1'b1, port_vc_arb_pkg::ADDR_VC_CAP_TWO, $urandom, 4'hf);
      apb(1'b0, port_vc_arb_pkg::ADDR_VC_RES_CAP_ZERO, 32'h0, 4'h0);
      check(rd, 32'h047f0009);
      apb(1'b0, port_vc_arb_pkg::ADDR_VC_CAP_TWO, 32'h0, 4'h0);
      check(rd, 32'h0);
    end
    apb(1'b0, 12'h1f0, 32'h0, 4'h0);
    check(rd, 32'h0);
    apb(1'b0, 12'h000, 32'h0, 4'h0);
    check(rd, 32'h0);
    apb(1'b1, port_vc_arb_pkg::ADDR_EXT_VC_COUNT, 32'h1, 4'hf);
    apb(1'b0, port_vc_arb_pkg::ADDR_VC_CAP_TWO, 32'h0, 4'h0);
    check(rd, 32'h03000003);
    // Every select code, with noise in the reserved and status bits.
    for (int s = 0; s < 8; s++) begin
      rnd = $urandom;
      apb(1'b1, port_vc_arb_pkg::ADDR_VC_CTRL_STAT, {rnd[31:4], 3'(s), 1'b0}, 4'hf);
      check({30'h0, vc_arb_scheme}, (s == 1) ? 32'h1 : 32'h0);
      if (s < 2) begin
        apb(1'b0, port_vc_arb_pkg::ADDR_VC_CTRL_STAT, 32'h0, 4'h0);
        check(rd, ctrl_exp(3'(s), 1'b0));
      end
    end
    load_check(3'h1);
    // Random table contents and strobes, each followed by a load.
    for (int k = 0; k < 6; k++) begin
      for (int w = 0; w < port_vc_arb_pkg::TABLE_WORDS; w++) begin
        rnd = $urandom;
        stb = (k == 0) ? 4'hf : 4'($urandom_range(15, 1));
        apb(1'b1, port_vc_arb_pkg::ADDR_VC_ARB_TABLE + 12'(4 * w), rnd, stb);
        tbl[w] = merge(tbl[w], rnd, stb);
      end
      apb(1'b0, port_vc_arb_pkg::ADDR_VC_CTRL_STAT, 32'h0, 4'h0);
      check(rd, ctrl_exp(cur_sel, 1'b1));
      load_check(3'(k % 2));
    end
    finish_test();
  end

  // A hang is cut short well beyond the few hundred cycles the tests take.
  initial begin
    repeat (20000) @(posedge pclk);
    num_errors++;
    finish_test();
  end
endmodule : tb_port_vc_arbitration_regs
